// ==== shared/lcdd_pkg.sv ====
// constants, types and timing for the character display instruction decoder
package lcdd_pkg;

    // wishbone byte offsets
    localparam logic [3:0] LCDD_ADR_INSTR = 4'h0;
    localparam logic [3:0] LCDD_ADR_DATA = 4'h4;

    // timing
    localparam int LCDD_CLK_NS = 100;
    localparam int LCDD_T_SHORT_NS = 18500;
    localparam int LCDD_T_LONG_NS = 760000;
    localparam int LCDD_T_BLINK_NS = 185000000;
    localparam int LCDD_SHORT_CYC = (LCDD_T_SHORT_NS + LCDD_CLK_NS - 1) / LCDD_CLK_NS;
    localparam int LCDD_LONG_CYC = (LCDD_T_LONG_NS + LCDD_CLK_NS - 1) / LCDD_CLK_NS;
    localparam int LCDD_BLINK_CYC = LCDD_T_BLINK_NS / LCDD_CLK_NS;

    // display ram addressing
    localparam logic [6:0] LCDD_L1_LAST = 7'h27;
    localparam logic [6:0] LCDD_L2_FIRST = 7'h40;
    localparam logic [6:0] LCDD_L2_LAST = 7'h67;
    localparam logic [6:0] LCDD_ONE_LAST = 7'h4F;
    localparam logic [5:0] LCDD_SHIFT_LAST = 6'h27;
    localparam logic [7:0] LCDD_SPACE = 8'h20;
    localparam logic [6:0] LCDD_FILL_LAST = 7'h7F;

    // reset values
    localparam logic [6:0] LCDD_AC_RST = 7'h00;
    localparam logic LCDD_INC_RST = 1'b1;
    localparam logic LCDD_SHW_RST = 1'b0;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_STATUS,
        OP_DREAD,
        OP_DWRITE,
        OP_CLEAR,
        OP_HOME,
        OP_ENTRY,
        OP_ONOFF,
        OP_SHIFT,
        OP_FUNC,
        OP_GADDR,
        OP_DADDR
    } lcdd_op_t;

    typedef struct packed {
        logic disp_on;
        logic cursor_on;
        logic blink_on;
    } lcdd_onoff_t;

    typedef struct packed {
        logic bus8;
        logic two_line;
        logic font11;
    } lcdd_func_t;

    localparam lcdd_onoff_t LCDD_ONOFF_RST = '{disp_on: 1'b0, cursor_on: 1'b0, blink_on: 1'b0};
    localparam lcdd_func_t LCDD_FUNC_RST = '{bus8: 1'b1, two_line: 1'b0, font11: 1'b0};

endpackage

// ==== rtl/lcdd_decoder.sv ====
// instruction decoder and execution logic of a character display controller
//
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/10ps

// Contract
// - data write stores byte into addressed display or glyph ram, 18.5 us
// - data read returns byte at addressed display or glyph ram location
// - clear fills display ram with 20H and zeroes address counter, 0.76 ms
// - clear homes cursor and forces entry direction to increment
// - return home zeroes address counter and undoes display shift, 0.76 ms
// - after ram access step counter up or down per direction bit
// - glyph ram accesses step the counter like display ram accesses
// - no display shift on reads, glyph accesses, or shift-on-write low
// - shift-on-write: display write shifts left if increment, right otherwise
// - display-enable zero blanks display, ram contents kept
// - cursor-visible bit shows or hides cursor, direction bit unaffected
// - blink alternates cursor cell and full block every 185 ms
// - cursor shift moves counter minus or plus one per direction bit
// - display shift moves whole display one place, counter unchanged
// - two-line mode: past 40th place of line one continue on line two
// - all display lines shift together in one step
// - function set selects bus width, line count and font
// - glyph address set loads six bits, selects glyph ram
// - display address set loads seven bits, selects display ram
// - status read returns busy flag in bit 7, counter below, no delay
// - other instructions complete in 18.5 us
// - busy flag high throughout every internal operation
// - two-line addresses are 00H-27H and 40H-67H
module lcdd_decoder
    import lcdd_pkg::*;
#(
    parameter int LONG_CYC = LCDD_LONG_CYC,
    parameter int BLINK_CYC = LCDD_BLINK_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic busy_flag_o,
    output lcdd_onoff_t onoff_o,
    output lcdd_func_t func_o,
    output logic blink_phase_o,
    output logic [5:0] shift_pos_o,
    output logic [6:0] addr_counter_o
);

    ////////////////////////////////////////////////////////////////////////
    // storage and state

    logic [7:0] display_ram [0:127];
    logic [7:0] glyph_ram [0:63];

    logic ack_q;
    logic [31:0] dat_q;
    logic [6:0] addr_counter_q;
    logic glyph_sel_q;
    logic inc_q;
    logic shw_q;
    lcdd_onoff_t onoff_q;
    lcdd_func_t func_q;
    logic [5:0] shift_q;
    logic [19:0] busy_cnt_q;
    logic clearing_q;
    logic [6:0] fill_q;
    logic [20:0] blink_cnt_q;
    logic blink_q;

    logic req;
    logic busy_flag;
    logic take;
    lcdd_op_t op;
    logic [7:0] byte_i;
    logic [7:0] ram_rd;
    logic [6:0] ac_next;
    logic ac_up;

    ////////////////////////////////////////////////////////////////////////
    // address counter stepping with line wrap

    function automatic logic [6:0] ac_step(input logic [6:0] a, input logic up,
                                           input logic glyph, input logic two);
        logic [6:0] r;
        r = a;
        if (glyph) begin
            r = up ? {1'b0, a[5:0] + 6'h01} : {1'b0, a[5:0] - 6'h01};
        end else if (two) begin
            if (up) begin
                if (a == LCDD_L1_LAST) begin
                    r = LCDD_L2_FIRST;
                end else if (a == LCDD_L2_LAST) begin
                    r = 7'h00;
                end else begin
                    r = a + 7'h01;
                end
            end else begin
                if (a == LCDD_L2_FIRST) begin
                    r = LCDD_L1_LAST;
                end else if (a == 7'h00) begin
                    r = LCDD_L2_LAST;
                end else begin
                    r = a - 7'h01;
                end
            end
        end else begin
            if (up) begin
                r = (a >= LCDD_ONE_LAST) ? 7'h00 : a + 7'h01;
            end else begin
                r = (a == 7'h00) ? LCDD_ONE_LAST : a - 7'h01;
            end
        end
        return r;
    endfunction

    function automatic logic [5:0] shift_step(input logic [5:0] s, input logic left);
        logic [5:0] r;
        r = s;
        if (left) begin
            r = (s == LCDD_SHIFT_LAST) ? 6'h00 : s + 6'h01;
        end else begin
            r = (s == 6'h00) ? LCDD_SHIFT_LAST : s - 6'h01;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // wishbone decode

    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign byte_i = wb_dat_i[7:0];
    assign busy_flag = (busy_cnt_q != 20'h00000) || clearing_q;

    always_comb begin
        op = OP_NONE;
        if (req && wb_adr_i == LCDD_ADR_DATA) begin
            if (!wb_we_i) begin
                op = OP_DREAD;
            end else if (wb_sel_i[0]) begin
                op = OP_DWRITE;
            end
        end else if (req && wb_adr_i == LCDD_ADR_INSTR) begin
            if (!wb_we_i) begin
                op = OP_STATUS;
            end else if (wb_sel_i[0]) begin
                casez (byte_i)
                    8'b1???????: op = OP_DADDR;
                    8'b01??????: op = OP_GADDR;
                    8'b001?????: op = OP_FUNC;
                    8'b0001????: op = OP_SHIFT;
                    8'b00001???: op = OP_ONOFF;
                    8'b000001??: op = OP_ENTRY;
                    8'b0000001?: op = OP_HOME;
                    8'b00000001: op = OP_CLEAR;
                    default: op = OP_NONE;
                endcase
            end
        end
    end

    // instructions and data writes are dropped while busy; data reads still return a byte but do not step; status never is
    assign take = (op != OP_NONE) && (op != OP_STATUS) && !busy_flag;
    assign ram_rd = glyph_sel_q ? glyph_ram[addr_counter_q[5:0]] : display_ram[addr_counter_q];
    assign ac_up = (op == OP_SHIFT) ? byte_i[2] : inc_q;
    assign ac_next = ac_step(addr_counter_q, ac_up, glyph_sel_q, func_q.two_line);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            if (req) begin
                if (op == OP_STATUS) begin
                    dat_q <= {24'h000000, busy_flag, addr_counter_q};
                end else if (op == OP_DREAD) begin
                    dat_q <= {24'h000000, ram_rd};
                end else begin
                    dat_q <= 32'h0000_0000;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address counter and ram select

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_counter_q <= LCDD_AC_RST;
            glyph_sel_q <= 1'b0;
        end else if (take) begin
            case (op)
                OP_DREAD, OP_DWRITE: addr_counter_q <= ac_next;
                OP_CLEAR, OP_HOME: begin
                    addr_counter_q <= 7'h00;
                    glyph_sel_q <= 1'b0;
                end
                OP_SHIFT: begin
                    if (!byte_i[3]) begin
                        addr_counter_q <= ac_next;
                    end
                end
                OP_GADDR: begin
                    addr_counter_q <= {1'b0, byte_i[5:0]};
                    glyph_sel_q <= 1'b1;
                end
                OP_DADDR: begin
                    addr_counter_q <= byte_i[6:0];
                    glyph_sel_q <= 1'b0;
                end
                default: addr_counter_q <= addr_counter_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode registers

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            inc_q <= LCDD_INC_RST;
            shw_q <= LCDD_SHW_RST;
            onoff_q <= LCDD_ONOFF_RST;
            func_q <= LCDD_FUNC_RST;
        end else if (take) begin
            case (op)
                OP_CLEAR: inc_q <= 1'b1;
                OP_ENTRY: begin
                    inc_q <= byte_i[1];
                    shw_q <= byte_i[0];
                end
                OP_ONOFF: begin
                    onoff_q.disp_on <= byte_i[2];
                    onoff_q.cursor_on <= byte_i[1];
                    onoff_q.blink_on <= byte_i[0];
                end
                OP_FUNC: begin
                    func_q.bus8 <= byte_i[4];
                    func_q.two_line <= byte_i[3];
                    func_q.font11 <= byte_i[2];
                end
                default: inc_q <= inc_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // display shift, one offset shared by every line

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_q <= 6'h00;
        end else if (take) begin
            case (op)
                OP_CLEAR, OP_HOME: shift_q <= 6'h00;
                OP_DWRITE: begin
                    if (shw_q && !glyph_sel_q) begin
                        shift_q <= shift_step(shift_q, inc_q);
                    end
                end
                OP_SHIFT: begin
                    if (byte_i[3]) begin
                        shift_q <= shift_step(shift_q, !byte_i[2]);
                    end
                end
                default: shift_q <= shift_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // execution timer

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_cnt_q <= 20'h00000;
        end else if (take) begin
            if (op == OP_CLEAR || op == OP_HOME) begin
                busy_cnt_q <= 20'(LONG_CYC);
            end else begin
                busy_cnt_q <= 20'(LCDD_SHORT_CYC);
            end
        end else if (busy_cnt_q != 20'h00000) begin
            busy_cnt_q <= busy_cnt_q - 20'h00001;
        end
    end

    // fill runs one cell per cycle; busy also waits for it if the timer is short
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clearing_q <= 1'b0;
            fill_q <= 7'h00;
        end else if (take && op == OP_CLEAR) begin
            clearing_q <= 1'b1;
            fill_q <= 7'h00;
        end else if (clearing_q) begin
            fill_q <= fill_q + 7'h01;
            if (fill_q == LCDD_FILL_LAST) begin
                clearing_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ram writes

    always_ff @(posedge clk_i) begin
        if (clearing_q) begin
            display_ram[fill_q] <= LCDD_SPACE;
        end else if (take && op == OP_DWRITE && !glyph_sel_q) begin
            display_ram[addr_counter_q] <= byte_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (take && op == OP_DWRITE && glyph_sel_q) begin
            glyph_ram[addr_counter_q[5:0]] <= byte_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // blink timer, restarts whenever blink is off

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            blink_cnt_q <= 21'h000000;
            blink_q <= 1'b0;
        end else if (!onoff_q.blink_on) begin
            blink_cnt_q <= 21'h000000;
            blink_q <= 1'b0;
        end else if (blink_cnt_q == 21'(BLINK_CYC - 1)) begin
            blink_cnt_q <= 21'h000000;
            blink_q <= !blink_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 21'h000001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign busy_flag_o = busy_flag;
    assign onoff_o = onoff_q;
    assign func_o = func_q;
    assign blink_phase_o = blink_q;
    assign shift_pos_o = shift_q;
    assign addr_counter_o = addr_counter_q;

endmodule // lcdd_decoder

// ==== test/lcdd_decoder_properties.sv ====
// port assertions for the instruction decoder
`timescale 1ns/10ps
module lcdd_decoder_chk
    import lcdd_pkg::*;
#(
    parameter int LONG_CYC = LCDD_LONG_CYC,
    parameter int BLINK_CYC = LCDD_BLINK_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic busy_flag_o,
    input wire lcdd_onoff_t onoff_o,
    input wire lcdd_func_t func_o,
    input wire logic blink_phase_o,
    input wire logic [5:0] shift_pos_o,
    input wire logic [6:0] addr_counter_o
);
    // clear runs the long count with the cell fill running alongside it, plus 500 cycles of margin
    localparam int CLR_HI = LONG_CYC + 500;
    wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic ins = take && wb_we_i && wb_adr_i == LCDD_ADR_INSTR && wb_sel_i[0] && !busy_flag_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    chk_ack_next: assert property (take |=> wb_ack_o)
        else $error("request not acknowledged");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_status_word: assert property (take && !wb_we_i && wb_adr_i == LCDD_ADR_INSTR |=>
        wb_dat_o[7:0] == {$past(busy_flag_o), $past(addr_counter_o)})
        else $error("status word wrong");
    chk_busy_rise: assert property (ins && wb_dat_i[7:0] != 8'h00 |=> busy_flag_o)
        else $error("busy not raised");
    chk_short_busy: assert property (ins && wb_dat_i[7:2] != 6'h00 |->
        ##184 busy_flag_o ##[1:3] !busy_flag_o)
        else $error("short busy length wrong");
    chk_clear_done: assert property (ins && wb_dat_i[7:0] == 8'h01 |->
        ##[1:CLR_HI] (!busy_flag_o && addr_counter_o == 7'h00 && shift_pos_o == 6'h00))
        else $error("clear did not finish home");
    chk_busy_refuse: assert property (take && wb_we_i && busy_flag_o |=>
        $stable(onoff_o) && $stable(func_o) && $stable(shift_pos_o))
        else $error("write acted while busy");
    chk_disp_shift: assert property (ins && wb_dat_i[7:2] == 6'b000110 |=>
        addr_counter_o == $past(addr_counter_o) && shift_pos_o ==
        ($past(shift_pos_o) == LCDD_SHIFT_LAST ? 6'h00 : $past(shift_pos_o) + 6'h01))
        else $error("display shift wrong");
    chk_cursor_step: assert property (ins && wb_dat_i[7:2] == 6'b000101 &&
        addr_counter_o < 7'h27 |=> addr_counter_o == $past(addr_counter_o) + 7'h01
        && $stable(shift_pos_o))
        else $error("cursor right wrong");
    chk_blink_off: assert property (!onoff_o.blink_on [*2] |-> !blink_phase_o)
        else $error("blink phase while off");
    // switching blink off legally drops the phase at once, so only a running blink must hold
    chk_blink_hold: assert property (onoff_o.blink_on && $changed(blink_phase_o) |=>
        ($stable(blink_phase_o) || !$past(onoff_o.blink_on)) [*8])
        else $error("blink toggled early");
endmodule // lcdd_decoder_chk

bind lcdd_decoder lcdd_decoder_chk #(.LONG_CYC(LONG_CYC), .BLINK_CYC(BLINK_CYC))
    i_lcdd_decoder_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .busy_flag_o(busy_flag_o), .onoff_o(onoff_o), .func_o(func_o),
    .blink_phase_o(blink_phase_o), .shift_pos_o(shift_pos_o),
    .addr_counter_o(addr_counter_o));

// ==== test/lcdd_host_model.sv ====
// host model issuing classic wishbone cycles to the decoder
`timescale 1ns/10ps
module lcdd_host_model
    import lcdd_pkg::*;
(
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [3:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 4'h0;
        sel_o = 4'hF;
        dat_o = 32'h0;
    end
    // request held until ack is sampled, released only then
    task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        sel_o <= 4'hF;
        adr_o <= a;
        dat_o <= {24'h000000, d};
        @(posedge clk_i);
        while (ack_i !== 1'b1) @(posedge clk_i);
        q = dat_i[7:0];
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
    endtask
    // polling instead of timing, so slow or fast device both work
    task automatic wait_ready();
        logic [7:0] s;
        int n;
        s = 8'h80;
        n = 0;
        while (s[7] !== 1'b0 && n < 20000) begin
            xfer(1'b0, LCDD_ADR_INSTR, 8'h00, s);
            n++;
        end
    endtask
endmodule // lcdd_host_model

// ==== test/tb_lcdd_decoder.sv ====
// self-checking testbench for the instruction decoder
`timescale 1ns/10ps
module tb_lcdd_decoder
    import lcdd_pkg::*;
;
    localparam int LONG = 200;
    localparam int BLINK = 16;
    logic clk_i, rst_i, cyc, stb, we, ack, busy, blink;
    logic [3:0] adr, sel;
    logic [31:0] wdat, rdat;
    lcdd_onoff_t onoff;
    lcdd_func_t func;
    logic [5:0] shp;
    logic [6:0] ac;
    int num_errors = 0;
    int check_count = 0;
    int cyc_cnt = 0;
    ////////////////////////////////////////////////////////////////////////////////
    lcdd_host_model i_lcdd_host_model (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat),
        .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
    lcdd_decoder #(.LONG_CYC(LONG), .BLINK_CYC(BLINK)) i_lcdd_decoder (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .busy_flag_o(busy), .onoff_o(onoff), .func_o(func), .blink_phase_o(blink),
        .shift_pos_o(shp), .addr_counter_o(ac));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) cyc_cnt <= cyc_cnt + 1;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic ins(input logic [7:0] d);
        logic [7:0] q;
        i_lcdd_host_model.xfer(1'b1, LCDD_ADR_INSTR, d, q);
        i_lcdd_host_model.wait_ready();
    endtask
    task automatic wr(input logic [7:0] d);
        logic [7:0] q;
        i_lcdd_host_model.xfer(1'b1, LCDD_ADR_DATA, d, q);
        i_lcdd_host_model.wait_ready();
    endtask
    task automatic rd(output logic [7:0] q);
        i_lcdd_host_model.xfer(1'b0, LCDD_ADR_DATA, 8'h00, q);
        i_lcdd_host_model.wait_ready();
    endtask
    task automatic t_reset();
        chk("onoff", 8'h00, {5'h00, onoff});
        chk("func", 8'h04, {5'h00, func});
        chk("ac", 8'h00, {1'b0, ac});
        chk("busy", 8'h00, {7'h00, busy});
    endtask
    task automatic t_clear();
        int t0;
        logic [7:0] q;
        ins(8'h04);
        ins(8'h85);
        t0 = cyc_cnt;
        ins(8'h01);
        chk("clear_time", 8'h01, {7'h00, (cyc_cnt - t0) >= LONG});
        chk("clear_ac", 8'h00, {1'b0, ac});
        ins(8'hC5);
        rd(q);
        chk("clear_fill", 8'h20, q);
        chk("clear_inc", 8'h46, {1'b0, ac});
    endtask
    task automatic t_ram();
        logic [7:0] q;
        ins(8'h24);
        chk("func_b", 8'h01, {5'h00, func});
        ins(8'h38);
        chk("func_a", 8'h06, {5'h00, func});
        ins(8'h06);
        ins(8'hA6);
        for (int i = 0; i < 3; i++) wr(8'hA1 + 8'(i));
        chk("ac_wrap", 8'h41, {1'b0, ac});
        ins(8'hA6);
        for (int i = 0; i < 3; i++) begin
            rd(q);
            chk("ram_rd", 8'hA1 + 8'(i), q);
        end
        ins(8'h04);
        ins(8'hC0);
        wr(8'h5A);
        chk("ac_dec", 8'h27, {1'b0, ac});
    endtask
    task automatic t_glyph();
        logic [7:0] q;
        ins(8'h07);
        ins(8'h7F);
        wr(8'h11);
        chk("glyph_ac", 8'h00, {1'b0, ac});
        chk("glyph_shift", 8'h00, {2'b00, shp});
        ins(8'h7F);
        rd(q);
        chk("glyph_rd", 8'h11, q);
    endtask
    task automatic t_shift();
        logic [7:0] q;
        ins(8'h80);
        wr(8'h41);
        chk("shift_l", 8'h01, {2'b00, shp});
        ins(8'h05);
        wr(8'h42);
        chk("shift_r", 8'h00, {2'b00, shp});
        rd(q);
        chk("shift_rd", 8'h00, {2'b00, shp});
        ins(8'h80);
        ins(8'h1C);
        chk("disp_r", 8'h27, {2'b00, shp});
        chk("disp_ac", 8'h00, {1'b0, ac});
        ins(8'h18);
        chk("disp_l", 8'h00, {2'b00, shp});
        ins(8'h14);
        chk("cur_r", 8'h01, {1'b0, ac});
        ins(8'h10);
        chk("cur_l", 8'h00, {1'b0, ac});
        ins(8'h18);
        ins(8'h85);
        ins(8'h03);
        chk("home_shift", 8'h00, {2'b00, shp});
        chk("home_ac", 8'h00, {1'b0, ac});
        rd(q);
        chk("home_ram", 8'h41, q);
    endtask
    task automatic t_onoff();
        int n;
        logic b;
        logic [7:0] q;
        ins(8'h0F);
        chk("onoff_all", 8'h07, {5'h00, onoff});
        n = 0;
        b = blink;
        repeat (BLINK * 4) begin
            @(posedge clk_i);
            if (blink !== b) n++;
            b = blink;
        end
        chk("blink_tog", 8'h01, {7'h00, n >= 3 && n <= 4});
        ins(8'h0C);
        chk("cursor_off", 8'h04, {5'h00, onoff});
        i_lcdd_host_model.xfer(1'b1, LCDD_ADR_INSTR, 8'h08, q);
        i_lcdd_host_model.xfer(1'b1, LCDD_ADR_INSTR, 8'h0B, q);
        i_lcdd_host_model.wait_ready();
        chk("busy_drop", 8'h00, {5'h00, onoff});
        chk("blink_off", 8'h00, {7'h00, blink});
        i_lcdd_host_model.xfer(1'b0, 4'h8, 8'h00, q);
        chk("unmapped", 8'h00, q);
    endtask
    // mid-run reset while idle must bring on/off, function, address counter and display shift back
    task automatic t_rerun();
        ins(8'h1C);
        chk("pre_rst", 8'h27, {2'b00, shp});
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        chk("rst_shift", 8'h00, {2'b00, shp});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk_i);
        num_errors++;
        print_verdict();
    end
    initial begin
        rst_i = 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_clear();
        t_ram();
        t_glyph();
        t_shift();
        t_onoff();
        t_rerun();
        print_verdict();
    end
endmodule // tb_lcdd_decoder
